// ### src/rrf_consts.vh
// Constants for the reply framer: register map, fields, check word, response codes
`ifndef RRF_CONSTS_VH
`define RRF_CONSTS_VH

// Register byte addresses
`define RRF_CTRL_ADDR       8'h00
`define RRF_STAT_ADDR       8'h04
`define RRF_UNIT_ADDR       8'h08
`define RRF_BLKHDR_ADDR     8'h0C
`define RRF_DATA_ADDR       8'h10
`define RRF_RXCNT_ADDR      8'h14

// Control register bits
`define RRF_CTRL_START      0
`define RRF_CTRL_FROZEN     1
`define RRF_CTRL_FRZ_READ   2
`define RRF_CTRL_IND_SET    3
`define RRF_CTRL_IND_ACK    4
`define RRF_CTRL_MORE       5
`define RRF_CTRL_RXCLR      6

// Flag byte bit positions
`define RRF_FLAG_SHORT      7
`define RRF_FLAG_MORE       6
`define RRF_FLAG_FROZEN     5
`define RRF_FLAG_IND        4
`define RRF_FLAG_EVCHG      3
`define RRF_FLAG_EVLOG      2

// Data block header field and limits
`define RRF_LAST_BIT        7
`define RRF_BLOCKS_MAX      4
`define RRF_DATA_MAX        64

// Check word
`define RRF_CRC_POLY_REFL   16'hA001
`define RRF_CRC_INIT        16'h0000

// AXI response codes
`define RRF_RESP_OKAY       2'b00
`define RRF_RESP_SLVERR     2'b10

`endif

// ### src/rrf_crc16.v
// Bytewise reflected CRC16 step, LSB first
`timescale 1ns/10ps
`include "rrf_consts.vh"

module rrf_crc16 (
    input  wire [15:0] crc_in,
    input  wire [7:0]  data_in,
    output reg  [15:0] crc_out
);
    integer i;

    // Eight shifts per byte, lowest bit of the byte first
    always @* begin
        crc_out = crc_in ^ {8'h00, data_in};
        for (i = 0; i < 8; i = i + 1) begin
            if (crc_out[0]) begin
                crc_out = (crc_out >> 1) ^ `RRF_CRC_POLY_REFL;
            end else begin
                crc_out = crc_out >> 1;
            end
        end
    end
endmodule // rrf_crc16

// ### src/rrf_framer.v
// Reply framer with check word generator, receive checker and AXI4-Lite registers
// Function
// - Frame ends with CRC16 over preceding bytes
// - Received frame good when remainder is zero and at least three bytes came
// - Bytes enter check lowest bit first
// - Header is flag byte then unit address
// - Flag byte bit layout, bits 1:0 zero
// - Short flag set exactly when no blocks
// - Oversize reply sets the more-data flag; code takes it from control bit RRF_CTRL_MORE written by software
// - Frozen flag until frozen counts read
// - Indication flag held until master acknowledges
// - Event change and log flags never set
// - Several data blocks may follow header
// - Block: mark+function byte, length byte, data
// - Last mark set only in final block
// - Function code echoes or reports failure
// - Length counts data bytes, zero means none
// - Header, blocks, check word in order
// - Address zero means broadcast frame
`timescale 1ns/10ps
`include "rrf_consts.vh"

module rrf_framer (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg  [7:0]  tx_data,
    output reg         tx_valid,
    output reg         tx_last,
    input  wire        tx_ready,
    input  wire [7:0]  rx_data,
    input  wire        rx_valid,
    input  wire        rx_end,
    output reg         rx_good,
    output reg         rx_bcast,
    output reg         rx_bad
);
    // Transmit states
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_FLAG = 3'd1;
    localparam [2:0] ST_ADDR = 3'd2;
    localparam [2:0] ST_FUNC = 3'd3;
    localparam [2:0] ST_LEN  = 3'd4;
    localparam [2:0] ST_DATA = 3'd5;
    localparam [2:0] ST_CRCL = 3'd6;
    localparam [2:0] ST_CRCH = 3'd7;

    // Software state
    reg [7:0]  unit_addr_r;
    reg        frozen_r;
    reg        ind_r;
    reg        more_r;
    reg [6:0]  blk_func_r [0:`RRF_BLOCKS_MAX-1];
    reg [6:0]  blk_len_r  [0:`RRF_BLOCKS_MAX-1];
    reg [2:0]  blk_cnt_r;
    reg [7:0]  data_mem_r [0:`RRF_DATA_MAX-1];
    reg [6:0]  data_wr_r;
    reg [15:0] rx_good_cnt_r;
    reg [15:0] rx_bad_cnt_r;

    // Transmit, receive and bus handshake state
    reg [2:0]  st_r;
    reg [2:0]  blk_r;
    reg [6:0]  cnt_r;
    reg [6:0]  rd_r;
    reg [15:0] crc_tx_r;
    reg [15:0] crc_rx_r;
    reg [7:0]  rx_first_r;
    reg [1:0]  rx_n_r;
    reg        aw_hold_r;
    reg        w_hold_r;
    reg [7:0]  aw_addr_r;
    reg [31:0] w_data_r;

    wire [15:0] crc_tx_nxt;
    wire [15:0] crc_rx_nxt;
    wire        busy = (st_r != ST_IDLE);
    wire        tx_fire = tx_valid & tx_ready;
    wire        do_wr = aw_hold_r & w_hold_r & ~s_axi_bvalid;
    wire [7:0]  flag_byte;
    wire        last_blk = (blk_r == blk_cnt_r - 3'd1);

    rrf_crc16 u_crc_tx (
        .crc_in  (crc_tx_r),
        .data_in (tx_data),
        .crc_out (crc_tx_nxt)
    );

    rrf_crc16 u_crc_rx (
        .crc_in  (crc_rx_r),
        .data_in (rx_data),
        .crc_out (crc_rx_nxt)
    );

    // Flag byte; event bits tied low since no event log exists
    assign flag_byte = {(blk_cnt_r == 3'd0),
                        more_r,
                        frozen_r,
                        ind_r,
                        1'b0, 1'b0,
                        2'b00};

    // Either channel may land first; each is held until the other arrives
    assign s_axi_awready = ~aw_hold_r;
    assign s_axi_wready  = ~w_hold_r;
    assign s_axi_arready = ~s_axi_rvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r  <= 32'h0000_0000;
        end else begin
            if (s_axi_awvalid && !aw_hold_r) begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end else if (do_wr) begin
                aw_hold_r <= 1'b0;
            end
            if (s_axi_wvalid && !w_hold_r) begin
                w_hold_r <= 1'b1;
                w_data_r <= s_axi_wdata;
            end else if (do_wr) begin
                w_hold_r <= 1'b0;
            end
        end
    end

    // Register writes and flag tracking
    always @(posedge aclk) begin
        if (!aresetn) begin
            unit_addr_r  <= 8'h01;
            frozen_r     <= 1'b0;
            ind_r        <= 1'b0;
            more_r       <= 1'b0;
            blk_cnt_r    <= 3'd0;
            data_wr_r    <= 7'd0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RRF_RESP_OKAY;
        end else begin
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `RRF_RESP_OKAY;
                case (aw_addr_r)
                    `RRF_CTRL_ADDR: begin
                        // Set wins over clear when both requested
                        if (w_data_r[`RRF_CTRL_FROZEN]) begin
                            frozen_r <= 1'b1;
                        end else if (w_data_r[`RRF_CTRL_FRZ_READ]) begin
                            frozen_r <= 1'b0;
                        end
                        if (w_data_r[`RRF_CTRL_IND_SET]) begin
                            ind_r <= 1'b1;
                        end else if (w_data_r[`RRF_CTRL_IND_ACK]) begin
                            ind_r <= 1'b0;
                        end
                        if (!busy) begin
                            more_r <= w_data_r[`RRF_CTRL_MORE];
                        end
                    end
                    `RRF_UNIT_ADDR: begin
                        unit_addr_r <= w_data_r[7:0];
                    end
                    `RRF_BLKHDR_ADDR: begin
                        // Bits 6:0 function, 14:8 length, bit 16 restarts list
                        if (!busy) begin
                            if (w_data_r[16]) begin
                                blk_cnt_r <= 3'd0;
                                data_wr_r <= 7'd0;
                            end else if (blk_cnt_r < `RRF_BLOCKS_MAX) begin
                                blk_func_r[blk_cnt_r[1:0]] <= w_data_r[6:0];
                                blk_len_r[blk_cnt_r[1:0]]  <= w_data_r[14:8];
                                blk_cnt_r <= blk_cnt_r + 3'd1;
                            end else begin
                                s_axi_bresp <= `RRF_RESP_SLVERR;
                            end
                        end else begin
                            s_axi_bresp <= `RRF_RESP_SLVERR;
                        end
                    end
                    `RRF_DATA_ADDR: begin
                        if (!busy && data_wr_r < `RRF_DATA_MAX) begin
                            data_mem_r[data_wr_r[5:0]] <= w_data_r[7:0];
                            data_wr_r <= data_wr_r + 7'd1;
                        end else begin
                            s_axi_bresp <= `RRF_RESP_SLVERR;
                        end
                    end
                    `RRF_STAT_ADDR, `RRF_RXCNT_ADDR: begin
                        s_axi_bresp <= `RRF_RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp <= `RRF_RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // Register reads, one cycle after address taken
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `RRF_RESP_OKAY;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else if (s_axi_arvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `RRF_RESP_OKAY;
            case (s_axi_araddr)
                `RRF_CTRL_ADDR:   s_axi_rdata <= {26'h0, more_r, 1'b0, ind_r, 1'b0,
                                                  frozen_r, 1'b0};
                `RRF_STAT_ADDR:   s_axi_rdata <= {8'h00, flag_byte, 5'h00, blk_cnt_r,
                                                  1'b0, data_wr_r};
                `RRF_UNIT_ADDR:   s_axi_rdata <= {24'h0, unit_addr_r};
                `RRF_BLKHDR_ADDR: s_axi_rdata <= {15'h0, busy, 13'h0, blk_cnt_r};
                `RRF_DATA_ADDR:   s_axi_rdata <= {25'h0, data_wr_r};
                `RRF_RXCNT_ADDR:  s_axi_rdata <= {rx_bad_cnt_r, rx_good_cnt_r};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `RRF_RESP_SLVERR;
                end
            endcase
        end
    end

    // Transmit sequencer: header, blocks, check word
    always @(posedge aclk) begin
        if (!aresetn) begin
            st_r     <= ST_IDLE;
            blk_r    <= 3'd0;
            cnt_r    <= 7'd0;
            rd_r     <= 7'd0;
            crc_tx_r <= `RRF_CRC_INIT;
            tx_data  <= 8'h00;
            tx_valid <= 1'b0;
            tx_last  <= 1'b0;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    if (do_wr && aw_addr_r == `RRF_CTRL_ADDR &&
                        w_data_r[`RRF_CTRL_START]) begin
                        st_r     <= ST_FLAG;
                        crc_tx_r <= `RRF_CRC_INIT;
                        blk_r    <= 3'd0;
                        rd_r     <= 7'd0;
                        tx_data  <= flag_byte;
                        tx_valid <= 1'b1;
                    end
                end
                ST_FLAG: if (tx_fire) begin
                    crc_tx_r <= crc_tx_nxt;
                    tx_data  <= unit_addr_r;
                    st_r     <= ST_ADDR;
                end
                ST_ADDR: if (tx_fire) begin
                    crc_tx_r <= crc_tx_nxt;
                    if (blk_cnt_r == 3'd0) begin
                        tx_data <= crc_tx_nxt[7:0];
                        st_r    <= ST_CRCL;
                    end else begin
                        tx_data <= {(blk_cnt_r == 3'd1), blk_func_r[0]};
                        st_r    <= ST_FUNC;
                    end
                end
                ST_FUNC: if (tx_fire) begin
                    crc_tx_r <= crc_tx_nxt;
                    tx_data  <= {1'b0, blk_len_r[blk_r[1:0]]};
                    cnt_r    <= blk_len_r[blk_r[1:0]];
                    st_r     <= ST_LEN;
                end
                ST_LEN, ST_DATA: if (tx_fire) begin
                    crc_tx_r <= crc_tx_nxt;
                    if (cnt_r != 7'd0) begin
                        // Data bytes; zero length skips straight on
                        tx_data <= data_mem_r[rd_r[5:0]];
                        rd_r    <= rd_r + 7'd1;
                        cnt_r   <= cnt_r - 7'd1;
                        st_r    <= ST_DATA;
                    end else if (!last_blk) begin
                        blk_r   <= blk_r + 3'd1;
                        tx_data <= {(blk_r + 3'd2 == blk_cnt_r),
                                    blk_func_r[blk_r[1:0] + 2'd1]};
                        st_r    <= ST_FUNC;
                    end else begin
                        tx_data <= crc_tx_nxt[7:0];
                        st_r    <= ST_CRCL;
                    end
                end
                ST_CRCL: if (tx_fire) begin
                    tx_data <= crc_tx_r[15:8];
                    tx_last <= 1'b1;
                    st_r    <= ST_CRCH;
                end
                ST_CRCH: if (tx_fire) begin
                    tx_valid <= 1'b0;
                    tx_last  <= 1'b0;
                    st_r     <= ST_IDLE;
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    // Receive checker: verdict at rx_end from running remainder
    always @(posedge aclk) begin
        if (!aresetn) begin
            crc_rx_r      <= `RRF_CRC_INIT;
            rx_first_r    <= 8'h00;
            rx_n_r        <= 2'd0;
            rx_good       <= 1'b0;
            rx_bad        <= 1'b0;
            rx_bcast      <= 1'b0;
            rx_good_cnt_r <= 16'h0000;
            rx_bad_cnt_r  <= 16'h0000;
        end else begin
            rx_good <= 1'b0;
            rx_bad  <= 1'b0;
            if (do_wr && aw_addr_r == `RRF_CTRL_ADDR && w_data_r[`RRF_CTRL_RXCLR]) begin
                rx_good_cnt_r <= 16'h0000;
                rx_bad_cnt_r  <= 16'h0000;
            end
            if (rx_valid) begin
                crc_rx_r <= crc_rx_nxt;
                if (rx_n_r != 2'd3) begin
                    rx_n_r <= rx_n_r + 2'd1;
                end
                if (rx_n_r == 2'd1) begin
                    rx_first_r <= rx_data; // Address byte
                end
            end
            if (rx_end) begin
                crc_rx_r <= `RRF_CRC_INIT;
                rx_n_r   <= 2'd0;
                // Too-short frames and nonzero remainders are dropped
                if (crc_rx_r == 16'h0000 && rx_n_r == 2'd3) begin
                    rx_good       <= 1'b1;
                    rx_bcast      <= (rx_first_r == 8'h00);
                    rx_good_cnt_r <= rx_good_cnt_r + 16'h0001;
                end else begin
                    rx_bad       <= 1'b1;
                    rx_bad_cnt_r <= rx_bad_cnt_r + 16'h0001;
                end
            end
        end
    end
endmodule // rrf_framer

// ### bench/rrf_step.svh
// Check word step shared by the bench-side modules
function automatic logic [15:0] step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] s;
    s = c ^ {8'h00, d};
    // Reflected form, lowest bit of the byte enters first
    for (int i = 0; i < 8; i++)
        s = s[0] ? (s >> 1) ^ 16'hA001 : s >> 1;
    return s;
endfunction

// ### bench/rrf_chk.sv
// Port checker for the reply framer
`timescale 1ns/10ps
module rrf_chk (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [7:0]  tx_data,
    input wire        tx_valid,
    input wire        tx_last,
    input wire        tx_ready,
    input wire [7:0]  rx_data,
    input wire        rx_valid,
    input wire        rx_end,
    input wire        rx_good,
    input wire        rx_bcast,
    input wire        rx_bad
);
    `include "rrf_step.svh"
    reg  [15:0] tcrc_r, rcrc_r, rem_r;
    reg  [3:0]  idx_r;
    reg  [1:0]  ridx_r;
    reg  [7:0]  radr_r;
    reg         short_r;
    wire        tx_hs = tx_valid & tx_ready;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_tx_end; tx_hs && tx_last; endsequence
    sequence s_ar_hs; s_axi_arvalid && s_axi_arready; endsequence
    // Running check word and byte index of outgoing frames
    always @(posedge aclk) begin
        if (!aresetn) begin
            tcrc_r <= 16'h0000;
            idx_r <= 4'h0;
            short_r <= 1'b0;
        end else if (tx_hs) begin
            tcrc_r <= tx_last ? 16'h0000 : step(tcrc_r, tx_data);
            idx_r <= tx_last ? 4'h0 : (idx_r == 4'hF ? idx_r : idx_r + 4'h1);
            if (idx_r == 4'h0)
                short_r <= tx_data[7];
        end
    end
    // Incoming frame remainder; fewer than three bytes counts as failing
    always @(posedge aclk) begin
        if (!aresetn) begin
            rcrc_r <= 16'h0000;
            rem_r <= 16'h0000;
            ridx_r <= 2'h0;
            radr_r <= 8'h00;
        end else if (rx_valid) begin
            rcrc_r <= step(rcrc_r, rx_data);
            ridx_r <= (ridx_r == 2'h3) ? ridx_r : ridx_r + 2'h1;
            if (ridx_r == 2'h1)
                radr_r <= rx_data;
        end else if (rx_end) begin
            rem_r <= (ridx_r == 2'h3) ? rcrc_r : 16'hFFFF;
            rcrc_r <= 16'h0000;
            ridx_r <= 2'h0;
        end
    end
    AST_TX_CRC: assert property (s_tx_end |-> step(tcrc_r, tx_data) == 16'h0000)
        else $error("frame check word leaves nonzero remainder");
    AST_SHORT: assert property (s_tx_end |-> short_r == (idx_r == 4'h3))
        else $error("short flag disagrees with frame length");
    AST_FLAG_LOW: assert property (tx_valid && idx_r == 4'h0 |-> tx_data[3:0] == 4'h0)
        else $error("flag byte low bits not zero");
    AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("frame byte changed before taken");
    AST_RX_GOOD: assert property (rx_good |-> $past(rx_end) && rem_r == 16'h0000)
        else $error("frame accepted with bad remainder");
    AST_RX_VERDICT: assert property (rx_end |=> rx_bad == (rem_r != 16'h0000) && rx_good != rx_bad)
        else $error("wrong verdict after frame end");
    AST_BCAST: assert property (rx_good |-> rx_bcast == (radr_r == 8'h00))
        else $error("broadcast indication wrong");
    AST_RD_ANS: assert property (s_ar_hs |=> s_axi_rvalid)
        else $error("read answer late");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped before taken");
endmodule // rrf_chk
bind rrf_framer rrf_chk chk_u (.aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_end(rx_end), .rx_good(rx_good),
    .rx_bcast(rx_bcast), .rx_bad(rx_bad));

// ### bench/rrf_master.sv
// Master station model on the serial side of the framer
`timescale 1ns/10ps
module rrf_master (
    input  wire       aclk,
    input  wire       stall,
    input  wire [7:0] tx_data,
    input  wire       tx_valid,
    input  wire       tx_last,
    output reg        tx_ready,
    output reg  [7:0] rx_data,
    output reg        rx_valid,
    output reg        rx_end,
    input  wire       rx_good,
    input  wire       rx_bcast,
    input  wire       rx_bad
);
    `include "rrf_step.svh"
    logic [7:0] got[$];
    int         n_frames, n_good, n_bad;
    logic       bcast, sending;
    initial begin
        {tx_ready, rx_valid, rx_end, sending, bcast} = 5'h00;
        rx_data = 8'h00;
        {n_frames, n_good, n_bad} = '0;
    end
    // Take device bytes; a stall only lets every other cycle through
    always @(posedge aclk) begin
        tx_ready <= stall ? ~tx_ready : 1'b1;
        if (tx_valid && tx_ready)
            got.push_back(tx_data);
        if (tx_valid && tx_ready && tx_last)
            n_frames++;
        if (rx_good)
            bcast <= rx_bcast;
        n_good += rx_good;
        n_bad += rx_bad;
        // Idle line never repeats the last byte
        if (!sending)
            rx_data <= ~rx_data;
    end
    // Send a frame; flip corrupts the high check byte
    task automatic send(input logic [7:0] b[$], input logic [7:0] flip);
        logic [15:0] c;
        c = 16'h0000;
        foreach (b[i]) c = step(c, b[i]);
        b.push_back(c[7:0]);
        b.push_back(c[15:8] ^ flip);
        sending = 1'b1;
        foreach (b[i]) begin
            @(posedge aclk);
            rx_data <= b[i];
            rx_valid <= 1'b1;
        end
        @(posedge aclk);
        rx_valid <= 1'b0;
        rx_end <= 1'b1;
        @(posedge aclk);
        rx_end <= 1'b0;
        sending = 1'b0;
    endtask
endmodule // rrf_master

// ### bench/rtu_reply_framer_crc_test.sv
// Self-checking bench for the reply framer
`timescale 1ns/10ps
`include "rrf_consts.vh"
module rtu_reply_framer_crc_test;
    `include "rrf_step.svh"
    reg         aclk, aresetn, stall, awvalid, wvalid, bready, arvalid, rready;
    reg  [7:0]  awaddr, araddr;
    reg  [31:0] wdata, rd;
    reg  [1:0]  resp;
    wire        awready, wready, bvalid, arready, rvalid;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    wire [7:0]  tx_data, rx_data;
    wire        tx_valid, tx_last, tx_ready, rx_valid, rx_end, rx_good, rx_bcast, rx_bad;
    int         errors, n_compared, nf;
    logic [7:0] eq[$];
    rrf_framer dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
        .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_end(rx_end),
        .rx_good(rx_good), .rx_bcast(rx_bcast), .rx_bad(rx_bad));
    rrf_master mm_u (.aclk(aclk), .stall(stall), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_last(tx_last), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_end(rx_end), .rx_good(rx_good), .rx_bcast(rx_bcast), .rx_bad(rx_bad));
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Bus write; handshakes judged from values settled just after each edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit aw, w, b;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        forever begin
            #1;
            {aw, w, b, resp} = {awvalid & awready, wvalid & wready, bvalid, bresp};
            @(posedge aclk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (b) begin
                bready <= 1'b0;
                return;
            end
        end
    endtask
    task automatic rdx(input logic [7:0] a);
        bit ar, r;
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        forever begin
            #1;
            {ar, r, resp, rd} = {arvalid & arready, rvalid, rresp, rdata};
            @(posedge aclk);
            if (ar) arvalid <= 1'b0;
            if (r) begin
                rready <= 1'b0;
                return;
            end
        end
    endtask
    // Append check word to the expected body, wait for the frame, compare
    task automatic expect_frame();
        logic [15:0] c;
        c = 16'h0000;
        foreach (eq[i]) c = step(c, eq[i]);
        eq.push_back(c[7:0]);
        eq.push_back(c[15:8]);
        nf++;
        while (mm_u.n_frames < nf) @(posedge aclk);
        check(mm_u.got.size(), eq.size());
        foreach (eq[i]) check(mm_u.got[i], eq[i]);
        mm_u.got.delete();
        eq.delete();
    endtask
    task automatic t_reset();
        rdx(`RRF_UNIT_ADDR);
        check(rd, 32'h0000_0001);
        rdx(`RRF_STAT_ADDR);
        check(rd[23:16], 8'h80);
        rdx(8'h3C);
        check(resp, `RRF_RESP_SLVERR);
        wr(8'h3C, 32'h0000_0000);
        check(resp, `RRF_RESP_SLVERR);
    endtask
    task automatic t_short();
        wr(`RRF_UNIT_ADDR, 32'h0000_005A);
        wr(`RRF_CTRL_ADDR, 32'h0000_0001);
        eq = {8'h80, 8'h5A};
        expect_frame();
    endtask
    // Two blocks, the first empty, with the line stalling
    task automatic t_blocks();
        stall <= 1'b1;
        wr(`RRF_BLKHDR_ADDR, 32'h0000_007F);
        wr(`RRF_BLKHDR_ADDR, 32'h0000_0207);
        wr(`RRF_DATA_ADDR, 32'h0000_00A5);
        wr(`RRF_DATA_ADDR, 32'h0000_003C);
        rdx(`RRF_STAT_ADDR);
        check({rd[10:8], rd[6:0]}, {3'h2, 7'h02});
        wr(`RRF_CTRL_ADDR, 32'h0000_0001);
        eq = {8'h00, 8'h5A, 8'h7F, 8'h00, 8'h87, 8'h02, 8'hA5, 8'h3C};
        expect_frame();
        stall <= 1'b0;
        wr(`RRF_BLKHDR_ADDR, 32'h0001_0000);
    endtask
    task automatic t_rx();
        mm_u.send({8'h00, 8'h5A, 8'h81, 8'h00}, 8'h00);
        repeat (3) @(posedge aclk);
        check({mm_u.n_good[30:0], mm_u.bcast}, {31'h1, 1'b0});
        mm_u.send({8'h00, 8'h00, 8'h81, 8'h00}, 8'h00);
        repeat (3) @(posedge aclk);
        check({mm_u.n_good[30:0], mm_u.bcast}, {31'h2, 1'b1});
        mm_u.send({8'h00, 8'h5A, 8'h81, 8'h00}, 8'h01);
        repeat (20) @(posedge aclk);
        check({mm_u.n_bad[15:0], mm_u.n_frames[15:0]}, {16'h1, nf[15:0]});
        rdx(`RRF_RXCNT_ADDR);
        check(rd, 32'h0001_0002);
        wr(`RRF_CTRL_ADDR, 32'h0000_0040);
        rdx(`RRF_RXCNT_ADDR);
        check(rd, 32'h0000_0000);
    endtask
    task automatic t_flags();
        wr(`RRF_CTRL_ADDR, 32'h0000_001E);
        rdx(`RRF_CTRL_ADDR);
        check(rd & 32'h0A, 32'h0A);
        wr(`RRF_CTRL_ADDR, 32'h0000_0021);
        eq = {8'hB0, 8'h5A};
        expect_frame();
        // Master follows the frozen and indication flags with a new request
        mm_u.send({8'h80, 8'h5A, 8'hA5, 8'h00}, 8'h00);
        wr(`RRF_CTRL_ADDR, 32'h0000_0034);
        wr(`RRF_CTRL_ADDR, 32'h0000_0021);
        eq = {8'hC0, 8'h5A};
        expect_frame();
    endtask
    initial begin
        {aresetn, stall, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
        {awaddr, araddr, wdata} = 48'h0;
        {errors, n_compared, nf} = '0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_short();
        t_blocks();
        t_rx();
        t_flags();
        tally_and_finish();
    end
    // Watchdog against a hang
    initial begin
        #100000;
        errors++;
        tally_and_finish();
    end
endmodule // rtu_reply_framer_crc_test
